//--- logic/sleep_wakeup_map.vh
// Register map, field positions and timing constants of the sleep/wake controller
`ifndef SLEEP_WAKEUP_MAP_VH
`define SLEEP_WAKEUP_MAP_VH
// ****************************************
// Register offsets
// ****************************************
`define ADDR_PIN_CHANGE_EN  4'h0
`define ADDR_INT_CONTROL    4'h1
`define ADDR_PERIPH_EN_1    4'h2
`define ADDR_PERIPH_EN_2    4'h3
`define ADDR_PERIPH_FLAG_1  4'h4
`define ADDR_PERIPH_FLAG_2  4'h5
`define ADDR_POWER_STATUS   4'h6
`define ADDR_CONFIG         4'h7
`define ADDR_EVT_STATUS     4'h8
`define ADDR_EVT_ENABLE     4'h9
`define ADDR_EVT_CLEAR      4'hA
// ****************************************
// Interrupt control fields
// ****************************************
`define IC_GLOBAL_EN  7
`define IC_TIMER0_EN  5
`define IC_EXT_EN     4
`define IC_CHANGE_EN  3
`define IC_TIMER0_FLG 2
`define IC_EXT_FLG    1
`define IC_CHANGE_FLG 0
// ****************************************
// Peripheral flag 1 and 2 fields
// ****************************************
`define P1_GATE  7
`define P1_ADC   6
`define P1_RX    5
`define P1_TX    4
`define P1_SSP   3
`define P1_CAP1  2
`define P1_TMR2  1
`define P1_TIMER_ONE  0
`define P2_CAP2  0
// ****************************************
// Power status, config and event status fields
// ****************************************
`define PS_TIMEOUT   1
`define PS_POWERDOWN 0
`define CFG_OSC_HI   1
`define CFG_OSC_LO   0
`define CFG_WDT_EN   2
`define CFG_T1_ASYNC 3
`define CFG_RX_SLAVE 4
`define CFG_ADC_RC   5
`define CFG_SSP_SLV  6
`define OSC_LP       2'h0
`define OSC_XT       2'h1
`define OSC_HS       2'h2
`define OSC_EXT_RC   2'h3
`define EVT_WAKE     0
`define EVT_NOP      1
`define EVT_RESET    2
`define EVT_PROG     3
// ****************************************
// Vector and timing
// ****************************************
`define INT_VECTOR     13'h0004
`define OST_PERIODS    1024
`define QUARTER_CYCLES 4
`define DUMMY_INSTR    2
`endif

//--- logic/sleep_wakeup_control.v
// Sleep entry, wake-up sources, status flags and programming-mode entry
`timescale 1ns/1ps
`default_nettype none
`include "sleep_wakeup_map.vh"

module sleep_wakeup_control #(
    parameter OSC_DIV = 1
) (
    // Clock and reset
    input  wire        mclk,
    input  wire        rst_n,
    // Register port
    input  wire [3:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    // Core handshake
    input  wire        sleep_exec,
    output reg         prefetch_next,
    output reg         core_halt,
    output reg         resume_exec,
    output reg         vector_fetch,
    output reg  [12:0] vector_addr,
    output reg         full_reset,
    output reg         osc_driver_on,
    // Watchdog
    input  wire        watchdog_timeout,
    output reg         watchdog_clear,
    // Interrupt sources
    input  wire        master_clear_pin_n,
    input  wire        ext_int_pin,
    input  wire [7:0]  pin_change_evt,
    input  wire        timer0_evt,
    input  wire [7:0]  periph_evt_1,
    input  wire        capture_two_evt,
    // Status out
    output reg         timeout_flag,
    output reg         powerdown_flag,
    output reg         irq,
    // Serial programming pins
    input  wire        serial_prog_clock,
    input  wire        serial_prog_data_in,
    output reg         serial_prog_data_out,
    output reg         serial_prog_data_oe,
    input  wire        master_clear_prog_voltage,
    input  wire        prog_data_drive,
    input  wire        prog_data_oe_req,
    output reg         prog_mode,
    output reg         prog_clock_sync,
    output reg         prog_data_sync
);

    // ****************************************
    // Constants and states
    // ****************************************
    localparam OST_COUNT  = `OST_PERIODS * OSC_DIV;
    localparam DUMMY_CNT  = `QUARTER_CYCLES * OSC_DIV * (1 + `DUMMY_INSTR);
    localparam CW         = 16;
    localparam ST_RUN     = 5'h01;
    localparam ST_SLEEP   = 5'h02;
    localparam ST_OST     = 5'h04;
    localparam ST_DUMMY   = 5'h08;
    localparam ST_VECTOR  = 5'h10;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    // Bits: 0 master clear, 1 ext pin, 2 prog clock, 3 prog data, 4 prog voltage
    wire [4:0] pin_raw = {master_clear_prog_voltage, serial_prog_data_in,
                          serial_prog_clock, ext_int_pin, master_clear_pin_n};
    reg  [4:0] sync1_reg;
    reg  [4:0] sync2_reg;
    reg  [4:0] sync3_reg;
    reg  [4:0] pin_reg;
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
            always @(posedge mclk) begin
                if (!rst_n) begin
                    sync1_reg[gi] <= (gi == 0) ? 1'h1 : 1'h0;
                    sync2_reg[gi] <= (gi == 0) ? 1'h1 : 1'h0;
                    sync3_reg[gi] <= (gi == 0) ? 1'h1 : 1'h0;
                    pin_reg[gi]   <= (gi == 0) ? 1'h1 : 1'h0;
                end else begin
                    sync1_reg[gi] <= pin_raw[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                    sync3_reg[gi] <= sync2_reg[gi];
                    // Glitch filter: change counts only when two stages agree
                    if (sync2_reg[gi] == sync3_reg[gi]) begin
                        pin_reg[gi] <= sync3_reg[gi];
                    end
                end
            end
        end
    endgenerate
    wire master_clear_pin_fall = (sync2_reg[0] == sync3_reg[0]) && !sync3_reg[0] && pin_reg[0];
    wire ext_rise  = (sync2_reg[1] == sync3_reg[1]) && sync3_reg[1] && !pin_reg[1];
    wire vpp_rise  = (sync2_reg[4] == sync3_reg[4]) && sync3_reg[4] && !pin_reg[4];

    // ****************************************
    // Registers
    // ****************************************
    reg [4:0]    state_reg;
    reg [CW-1:0] count_reg;
    reg [7:0]    pin_change_en_reg;
    reg [7:0]    int_control_reg;
    reg [7:0]    periph_en_1_reg;
    reg          periph_en_2_reg;
    reg [7:0]    periph_flag_1_reg;
    reg          periph_flag_2_reg;
    reg [6:0]    config_reg;
    reg [3:0]    evt_status_reg;
    reg [3:0]    evt_enable_reg;
    reg          wake_vector_reg;

    wire sleeping  = state_reg[1];
    wire osc_xtal  = (config_reg[`CFG_OSC_HI:`CFG_OSC_LO] != `OSC_EXT_RC);
    wire wdt_on    = config_reg[`CFG_WDT_EN];
    wire global_int_enable       = int_control_reg[`IC_GLOBAL_EN];

    // Clocked sources are masked while asleep; no clock reaches them
    reg [7:0] p1_mask;
    always @* begin
        p1_mask = 8'hFF;
        if (sleeping) begin
            p1_mask = 8'h00;
            p1_mask[`P1_TIMER_ONE] = config_reg[`CFG_T1_ASYNC];
            p1_mask[`P1_RX]   = config_reg[`CFG_RX_SLAVE];
            p1_mask[`P1_ADC]  = config_reg[`CFG_ADC_RC];
            p1_mask[`P1_SSP]  = config_reg[`CFG_SSP_SLV];
            p1_mask[`P1_CAP1] = 1'h1;
        end
    end
    wire [7:0] p1_set   = periph_evt_1 & p1_mask;
    wire       t0_set   = timer0_evt & !sleeping;
    wire       chg_set  = |(pin_change_evt & pin_change_en_reg);

    // Each source wakes only on its own enable; global enable ignored
    wire pending = (int_control_reg[`IC_TIMER0_EN] & int_control_reg[`IC_TIMER0_FLG])
                 | (int_control_reg[`IC_EXT_EN] & int_control_reg[`IC_EXT_FLG])
                 | (int_control_reg[`IC_CHANGE_EN] & int_control_reg[`IC_CHANGE_FLG])
                 | (|(periph_en_1_reg & periph_flag_1_reg))
                 | (periph_en_2_reg & periph_flag_2_reg);

    wire wr_ic  = reg_wr && (reg_addr == `ADDR_INT_CONTROL);
    wire wr_pf1 = reg_wr && (reg_addr == `ADDR_PERIPH_FLAG_1);
    wire wr_pf2 = reg_wr && (reg_addr == `ADDR_PERIPH_FLAG_2);
    wire sleep_go  = sleep_exec && state_reg[0] && !pending;
    wire sleep_nop = sleep_exec && state_reg[0] && pending;
    wire wdt_wake  = sleeping && wdt_on && watchdog_timeout;
    wire int_wake  = sleeping && pending;
    wire any_wake  = wdt_wake || int_wake;
    wire prog_enter = vpp_rise && !pin_reg[2] && !pin_reg[3];

    reg [3:0] evt_set;
    always @* begin
        evt_set = 4'h0;
        evt_set[`EVT_WAKE]  = any_wake;
        evt_set[`EVT_NOP]   = sleep_nop;
        evt_set[`EVT_RESET] = master_clear_pin_fall;
        evt_set[`EVT_PROG]  = prog_enter;
    end

    // ****************************************
    // Interrupt and enable registers
    // ****************************************
    always @(posedge mclk) begin
        if (!rst_n) begin
            pin_change_en_reg <= 8'h00;
            int_control_reg   <= 8'h00;
            periph_en_1_reg   <= 8'h00;
            periph_en_2_reg   <= 1'h0;
            periph_flag_1_reg <= 8'h00;
            periph_flag_2_reg <= 1'h0;
            config_reg        <= 7'h00;
            evt_status_reg    <= 4'h0;
            evt_enable_reg    <= 4'h0;
        end else begin
            if (reg_wr && reg_addr == `ADDR_PIN_CHANGE_EN) begin
                pin_change_en_reg <= reg_wdata;
            end
            if (reg_wr && reg_addr == `ADDR_PERIPH_EN_1) begin
                periph_en_1_reg <= reg_wdata;
            end
            if (reg_wr && reg_addr == `ADDR_PERIPH_EN_2) begin
                periph_en_2_reg <= reg_wdata[`P2_CAP2];
            end
            if (reg_wr && reg_addr == `ADDR_CONFIG) begin
                config_reg <= reg_wdata[6:0];
            end
            if (reg_wr && reg_addr == `ADDR_EVT_ENABLE) begin
                evt_enable_reg <= reg_wdata[3:0];
            end
            // Hardware set wins over a software write in the same cycle
            int_control_reg <= (wr_ic ? reg_wdata : int_control_reg)
                             | {5'h00, t0_set, ext_rise, chg_set};
            periph_flag_1_reg <= (wr_pf1 ? reg_wdata : periph_flag_1_reg) | p1_set;
            periph_flag_2_reg <= (wr_pf2 ? reg_wdata[`P2_CAP2] : periph_flag_2_reg)
                               | capture_two_evt;
            evt_status_reg <= (evt_status_reg
                             & ~((reg_wr && reg_addr == `ADDR_EVT_CLEAR) ?
                                 reg_wdata[3:0] : 4'h0))
                             | evt_set;
        end
    end

    // ****************************************
    // Sleep and wake sequencer
    // ****************************************
    always @(posedge mclk) begin
        if (!rst_n) begin
            state_reg       <= ST_RUN;
            count_reg       <= {CW{1'h0}};
            timeout_flag    <= 1'h1;
            powerdown_flag  <= 1'h1;
            prefetch_next   <= 1'h0;
            core_halt       <= 1'h0;
            resume_exec     <= 1'h0;
            vector_fetch    <= 1'h0;
            vector_addr     <= 13'h0000;
            full_reset      <= 1'h0;
            osc_driver_on   <= 1'h1;
            watchdog_clear  <= 1'h0;
            wake_vector_reg <= 1'h0;
        end else begin
            prefetch_next  <= 1'h0;
            resume_exec    <= 1'h0;
            vector_fetch   <= 1'h0;
            full_reset     <= 1'h0;
            watchdog_clear <= 1'h0;
            if (master_clear_pin_fall) begin
                // Master clear always ends in a full reset
                full_reset     <= 1'h1;
                state_reg      <= ST_RUN;
                core_halt      <= 1'h0;
                osc_driver_on  <= 1'h1;
            end else begin
                case (state_reg)
                    ST_RUN: begin
                        if (sleep_exec) begin
                            prefetch_next <= 1'h1;
                        end
                        if (sleep_go) begin
                            watchdog_clear <= 1'h1;
                            powerdown_flag <= 1'h0;
                            timeout_flag   <= 1'h1;
                            osc_driver_on  <= 1'h0;
                            core_halt      <= 1'h1;
                            state_reg      <= ST_SLEEP;
                        end
                    end
                    ST_SLEEP: begin
                        if (any_wake) begin
                            watchdog_clear  <= 1'h1;
                            osc_driver_on   <= 1'h1;
                            wake_vector_reg <= int_wake && global_int_enable;
                            if (wdt_wake && !int_wake) begin
                                timeout_flag <= 1'h0;
                            end
                            // Crystal needs a start-up wait
                            count_reg <= osc_xtal ? OST_COUNT[CW-1:0] : {CW{1'h0}};
                            state_reg <= ST_OST;
                        end
                    end
                    ST_OST: begin
                        if (count_reg <= {{(CW-1){1'h0}}, 1'h1}) begin
                            core_halt   <= 1'h0;
                            resume_exec <= 1'h1;
                            count_reg   <= DUMMY_CNT[CW-1:0];
                            state_reg   <= wake_vector_reg ? ST_DUMMY : ST_RUN;
                        end else begin
                            count_reg <= count_reg - {{(CW-1){1'h0}}, 1'h1};
                        end
                    end
                    ST_DUMMY: begin
                        // Prefetched instruction runs, then dummy cycles
                        if (count_reg <= {{(CW-1){1'h0}}, 1'h1}) begin
                            state_reg <= ST_VECTOR;
                        end else begin
                            count_reg <= count_reg - {{(CW-1){1'h0}}, 1'h1};
                        end
                    end
                    ST_VECTOR: begin
                        vector_fetch <= 1'h1;
                        vector_addr  <= `INT_VECTOR;
                        state_reg    <= ST_RUN;
                    end
                    default: begin
                        state_reg <= ST_RUN;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Programming mode pins
    // ****************************************
    always @(posedge mclk) begin
        if (!rst_n) begin
            prog_mode            <= 1'h0;
            prog_clock_sync      <= 1'h0;
            prog_data_sync       <= 1'h0;
            serial_prog_data_out <= 1'h0;
            serial_prog_data_oe  <= 1'h0;
        end else begin
            if (prog_enter) begin
                prog_mode <= 1'h1;
            end else if (!pin_reg[4]) begin
                prog_mode <= 1'h0;
            end
            // Clock is input only; data turns round on request
            prog_clock_sync      <= pin_reg[2];
            prog_data_sync       <= pin_reg[3];
            serial_prog_data_out <= prog_data_drive;
            serial_prog_data_oe  <= prog_mode && prog_data_oe_req;
        end
    end

    // ****************************************
    // Register read and interrupt line
    // ****************************************
    always @(posedge mclk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
            irq       <= 1'h0;
        end else begin
            irq <= |(evt_status_reg & evt_enable_reg);
            reg_rdata <= 8'h00;
            if (reg_rd) begin
                case (reg_addr)
                    `ADDR_PIN_CHANGE_EN:  reg_rdata <= pin_change_en_reg;
                    `ADDR_INT_CONTROL:    reg_rdata <= int_control_reg;
                    `ADDR_PERIPH_EN_1:    reg_rdata <= periph_en_1_reg;
                    `ADDR_PERIPH_EN_2:    reg_rdata <= {7'h00, periph_en_2_reg};
                    `ADDR_PERIPH_FLAG_1:  reg_rdata <= periph_flag_1_reg;
                    `ADDR_PERIPH_FLAG_2:  reg_rdata <= {7'h00, periph_flag_2_reg};
                    `ADDR_POWER_STATUS:   reg_rdata <= {6'h00, timeout_flag, powerdown_flag};
                    `ADDR_CONFIG:         reg_rdata <= {1'h0, config_reg};
                    `ADDR_EVT_STATUS:     reg_rdata <= {4'h0, evt_status_reg};
                    `ADDR_EVT_ENABLE:     reg_rdata <= {4'h0, evt_enable_reg};
                    default:              reg_rdata <= 8'h00;
                endcase
            end
        end
    end

endmodule
`default_nettype wire

//--- bench/sleep_wakeup_control_sva.sv
// Port-level checks of the sleep/wake controller
`timescale 1ns/1ps
`default_nettype none
module sleep_wakeup_control_sva #(
    parameter OSC_DIV = 1
) (
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        sleep_exec,
    input wire logic        prefetch_next,
    input wire logic        core_halt,
    input wire logic        resume_exec,
    input wire logic        vector_fetch,
    input wire logic [12:0] vector_addr,
    input wire logic        full_reset,
    input wire logic        osc_driver_on,
    input wire logic        watchdog_clear,
    input wire logic        master_clear_pin_n,
    input wire logic        timeout_flag,
    input wire logic        powerdown_flag,
    input wire logic        serial_prog_data_oe,
    input wire logic        prog_mode,
    input wire logic        prog_data_oe_req,
    input wire logic        prog_clock_sync,
    input wire logic        prog_data_sync
);
    localparam int VEC_GAP = 12 * OSC_DIV + 1;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ****************************************
    // Assertions
    // ****************************************
    a_sleep_prefetch: assert property (sleep_exec && !core_halt && !prog_mode |=> prefetch_next)
        else $error("no prefetch after sleep");
    a_sleep_entry: assert property (prefetch_next && core_halt |->
        !powerdown_flag && timeout_flag && !osc_driver_on && watchdog_clear)
        else $error("sleep entry flags wrong");
    a_nop_sleep: assert property (prefetch_next && !core_halt |->
        !watchdog_clear && $stable(powerdown_flag) && $stable(timeout_flag))
        else $error("no-op sleep changed state");
    a_wake_wdt: assert property ($rose(osc_driver_on) |-> watchdog_clear)
        else $error("wake without watchdog clear");
    logic [15:0] ost_cnt;
    always @(posedge mclk) ost_cnt <= core_halt && osc_driver_on ? ost_cnt + 16'h1 : 16'h0;
    a_wake_resume: assert property (ost_cnt <= 1026 * OSC_DIV)
        else $error("wake never resumed");
    a_vector_addr: assert property (vector_fetch |=> vector_addr == 13'h0004)
        else $error("vector address wrong");
    a_vector_gap: assert property (vector_fetch |-> $past(resume_exec, VEC_GAP))
        else $error("vector fetch spacing wrong");
    a_prog_oe: assert property (serial_prog_data_oe |-> $past(prog_mode) && $past(prog_data_oe_req))
        else $error("data pin driven outside program mode");
    a_prog_entry: assert property ($rose(prog_mode) |->
        $past(prog_clock_sync) == 1'b0 && $past(prog_data_sync) == 1'b0)
        else $error("program entry with clock or data high");
    a_master_clear_pin_reset: assert property ($fell(master_clear_pin_n) |-> ##[1:8] full_reset)
        else $error("master clear gave no reset");
endmodule
bind sleep_wakeup_control sleep_wakeup_control_sva #(.OSC_DIV(OSC_DIV)) u_sva (
    .mclk, .rst_n, .sleep_exec, .prefetch_next, .core_halt, .resume_exec, .vector_fetch,
    .vector_addr, .full_reset, .osc_driver_on, .watchdog_clear, .master_clear_pin_n,
    .timeout_flag, .powerdown_flag, .serial_prog_data_oe, .prog_mode, .prog_data_oe_req,
    .prog_clock_sync, .prog_data_sync);
`default_nettype wire

//--- bench/prog_pin_model.sv
// Programmer side of the serial programming pins
`timescale 1ns/1ps
`default_nettype none
module prog_pin_model (
    // Clock and request
    input  wire logic mclk,
    input  wire logic prog_enter,
    // Device data pin driver
    input  wire logic serial_prog_data_oe,
    input  wire logic serial_prog_data_out,
    // Pins seen by the device
    output wire logic serial_prog_clock,
    output wire logic serial_prog_data_in,
    output wire logic master_clear_prog_voltage
);
    logic [3:0] cnt = 4'h0;
    logic       pat = 1'b0;
    always @(posedge mclk) begin
        pat <= ~pat;
        if (!prog_enter)
            cnt <= 4'h0;
        else if (cnt != 4'hF)
            cnt <= cnt + 4'h1;
    end
    // No frames sent, so the clock stands low
    assign serial_prog_clock = 1'b0;
    // Voltage raised only after clock and data sat low for eight cycles
    assign master_clear_prog_voltage = prog_enter && cnt >= 4'h8;
    // Released line toggles so a stale value never passes
    assign serial_prog_data_in = serial_prog_data_oe ? serial_prog_data_out
        : (prog_enter && !master_clear_prog_voltage) ? 1'b0 : pat;
endmodule
`default_nettype wire

//--- bench/tb_sleep_wakeup_control.sv
// Register-driven tests of the sleep/wake controller
`timescale 1ns/1ps
`default_nettype none
module tb_sleep_wakeup_control;
    localparam int OSC_DIV = 1;
    logic        mclk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, sleep_exec = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00, pin_change_evt = 8'h00, periph_evt_1 = 8'h00;
    logic        watchdog_timeout = 1'b0, master_clear_pin_n = 1'b1, ext_int_pin = 1'b0;
    logic        timer0_evt = 1'b0, capture_two_evt = 1'b0, prog_enter = 1'b0;
    logic        prog_data_drive = 1'b0, prog_data_oe_req = 1'b0;
    wire  [7:0]  reg_rdata;
    wire  [12:0] vector_addr;
    wire         prefetch_next, core_halt, resume_exec, vector_fetch, full_reset, osc_driver_on;
    wire         watchdog_clear, timeout_flag, powerdown_flag, irq, serial_prog_data_out;
    wire         serial_prog_data_oe, prog_mode, prog_clock_sync, prog_data_sync;
    wire         serial_prog_clock, serial_prog_data_in, master_clear_prog_voltage;
    int          n_mismatch = 0, checked = 0, cyc = 0, n;

    always #2.5 mclk = ~mclk;
    sleep_wakeup_control #(.OSC_DIV(OSC_DIV)) DUT (.mclk, .rst_n, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .sleep_exec, .prefetch_next, .core_halt, .resume_exec,
        .vector_fetch, .vector_addr, .full_reset, .osc_driver_on, .watchdog_timeout,
        .watchdog_clear, .master_clear_pin_n, .ext_int_pin, .pin_change_evt, .timer0_evt,
        .periph_evt_1, .capture_two_evt, .timeout_flag, .powerdown_flag, .irq,
        .serial_prog_clock, .serial_prog_data_in, .serial_prog_data_out, .serial_prog_data_oe,
        .master_clear_prog_voltage, .prog_data_drive, .prog_data_oe_req, .prog_mode,
        .prog_clock_sync, .prog_data_sync);
    prog_pin_model u_prog (.mclk, .prog_enter, .serial_prog_data_oe, .serial_prog_data_out,
        .serial_prog_clock, .serial_prog_data_in, .master_clear_prog_voltage);

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 check({8'h00, reg_rdata}, {8'h00, e});
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    task automatic sleep_op();
        @(posedge mclk);
        sleep_exec <= 1'b1;
        @(posedge mclk);
        sleep_exec <= 1'b0;
        #1 check({15'h0, prefetch_next}, 16'h1);
    endtask
    // Bounded wait: 0 resume, 1 vector fetch, 2 full reset, 3 program mode
    task automatic wait_for(input int sel, input int lim, output int k);
        k = 0;
        while (k < lim && !((sel == 0 && resume_exec === 1'b1) || (sel == 1 && vector_fetch === 1'b1)
               || (sel == 2 && full_reset === 1'b1) || (sel == 3 && prog_mode === 1'b1))) begin
            @(posedge mclk);
            #1 k++;
        end
    endtask
    task automatic stop_test();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_mismatch++;
            stop_test();
        end
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        rd(4'h6, 8'h03);
        wr(4'h6, 8'h00);
        rd(4'h6, 8'h03);
        rd(4'hB, 8'h00);
        rd(4'hA, 8'h00);
        $display("test registers done");
        // RC mode, pin interrupt, global enable off
        wr(4'h7, 8'h03);
        wr(4'h1, 8'h10);
        sleep_op();
        check({15'h0, core_halt && watchdog_clear && !osc_driver_on}, 16'h1);
        rd(4'h6, 8'h02);
        @(posedge mclk) ext_int_pin <= 1'b1;
        wait_for(0, 40, n);
        check({15'h0, n < 40}, 16'h1);
        wait_for(1, 30, n);
        check(16'(n), 16'd30);
        @(posedge mclk) ext_int_pin <= 1'b0;
        rd(4'h6, 8'h02);
        // Flag still pending: sleep falls through
        sleep_op();
        check({14'h0, core_halt, watchdog_clear}, 16'h0);
        rd(4'h6, 8'h02);
        $display("test interrupt wake done");
        // Global enable on: vector after dummy cycles
        wr(4'h1, 8'h90);
        sleep_op();
        @(posedge mclk) ext_int_pin <= 1'b1;
        wait_for(0, 40, n);
        wait_for(1, 20, n);
        check(16'(n), 16'(12 * OSC_DIV + 1));
        tick(1);
        check({3'h0, vector_addr}, 16'h0004);
        @(posedge mclk) ext_int_pin <= 1'b0;
        wr(4'h1, 8'h00);
        $display("test vector done");
        // Crystal mode, watchdog wake
        wr(4'h7, 8'h05);
        sleep_op();
        @(posedge mclk) watchdog_timeout <= 1'b1;
        @(posedge mclk) watchdog_timeout <= 1'b0;
        #1 check({15'h0, watchdog_clear}, 16'h1);
        wait_for(0, 1100, n);
        check({15'h0, n > 1015 && n < 1030}, 16'h1);
        rd(4'h6, 8'h00);
        $display("test watchdog wake done");
        // Clocked or disabled sources must not wake
        wr(4'h7, 8'h03);
        wr(4'h2, 8'h02);
        wr(4'h1, 8'h20);
        sleep_op();
        @(posedge mclk);
        periph_evt_1 <= 8'h02;
        timer0_evt <= 1'b1;
        ext_int_pin <= 1'b1;
        @(posedge mclk);
        periph_evt_1 <= 8'h00;
        timer0_evt <= 1'b0;
        wait_for(0, 30, n);
        check(16'(n), 16'd30);
        wr(4'h3, 8'h01);
        @(posedge mclk) capture_two_evt <= 1'b1;
        @(posedge mclk) capture_two_evt <= 1'b0;
        wait_for(0, 30, n);
        check({15'h0, n < 30}, 16'h1);
        @(posedge mclk) ext_int_pin <= 1'b0;
        wr(4'h1, 8'h00);
        wr(4'h2, 8'h00);
        wr(4'h3, 8'h00);
        $display("test wake sources done");
        // Event interrupt: raise, mask, clear
        rd(4'h8, 8'h03);
        wr(4'h9, 8'h01);
        tick(2);
        check({15'h0, irq}, 16'h1);
        wr(4'h9, 8'h00);
        tick(2);
        check({15'h0, irq}, 16'h0);
        wr(4'h9, 8'h01);
        wr(4'hA, 8'h01);
        tick(2);
        check({15'h0, irq}, 16'h0);
        rd(4'h8, 8'h02);
        $display("test event irq done");
        // Master clear gives a full reset
        @(posedge mclk) master_clear_pin_n <= 1'b0;
        wait_for(2, 12, n);
        check({15'h0, n < 12}, 16'h1);
        @(posedge mclk) master_clear_pin_n <= 1'b1;
        tick(8);
        $display("test master clear done");
        // Programming entry and data pin turnaround
        @(posedge mclk) prog_enter <= 1'b1;
        wait_for(3, 40, n);
        check({15'h0, n < 40}, 16'h1);
        @(posedge mclk);
        prog_data_oe_req <= 1'b1;
        prog_data_drive <= 1'b1;
        tick(3);
        check({14'h0, serial_prog_data_oe, serial_prog_data_in}, 16'h3);
        @(posedge mclk) prog_data_drive <= 1'b0;
        tick(2);
        check({14'h0, serial_prog_data_oe, serial_prog_data_in}, 16'h2);
        @(posedge mclk);
        prog_data_oe_req <= 1'b0;
        prog_enter <= 1'b0;
        tick(12);
        check({14'h0, prog_mode, serial_prog_data_oe}, 16'h0);
        $display("test programming done");
        stop_test();
    end
endmodule
`default_nettype wire
